// file: logic/irq_fiq_mask_status_unit.sv
`timescale 1ns/1ps

// How it works
// - twenty-five sources, each on one fixed bit shared by all registers.
// - bit 1 software, bits 2 to 25 peripheral lines in fixed order.
// - bit 0 of normal and fast status and raw registers shows any fast request active.
// - normal status bit is raw bit AND normal enable bit, read only.
// - all 32 normal status bits ORed into the normal request output.
// - no priority encoding or vector; software scans the status bits.
// - normal raw bit follows its peripheral request line, read only.
// - normal enable write only sets bits; writing zero never disables.
// - each one written to normal clear drops that normal enable bit.
// - fast path has raw, enable, clear and status registers like normal.
// - fast status bits 31..1 ORed drive fast output and bit 0 of all four status and raw registers.
// - setting one path's enable bit clears the same bit of the other.
// - fast raw bit follows its peripheral request line, read only.
// - fast enable bit one lets a fast request through; zero writes ignored.
// - each one written to fast clear drops that fast enable bit, write only.
// - fast status bit is fast raw AND fast enable, readable at own address.
// - software control bits 1 and 2 drive source bit 1 past the masks.
module irq_fiq_mask_status_unit
   import irq_fiq_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   input  wire logic                we_i,
   input  wire logic [ADDR_W-1:0]   adr_i,
   input  wire logic [SEL_W-1:0]    sel_i,
   input  wire logic [DATA_W-1:0]   dat_i,
   output logic      [DATA_W-1:0]   dat_o,
   output logic                     ack_o,
   input  wire logic [PERIPH_N-1:0] periph_req_i,
   output logic                     irq_o,
   output logic                     fiq_o
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------

   // widen byte enables into a bit mask
   function automatic logic [DATA_W-1:0] lane_mask(input logic [SEL_W-1:0] sel);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < SEL_W; i++) begin
         m[i*8 +: 8] = {8{sel[i]}};
      end
      return m;
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [DATA_W-1:0]   periph_reg;
   logic [DATA_W-1:0]   en_normal_reg;
   logic [DATA_W-1:0]   en_fast_reg;
   logic [DATA_W-1:0]   sw_ctrl_reg;
   logic                ack_reg;
   logic [DATA_W-1:0]   rd_reg;
   logic                irq_reg;
   logic                fiq_reg;

   logic [DATA_W-1:0]   raw_normal;
   logic [DATA_W-1:0]   raw_fast;
   logic [DATA_W-1:0]   stat_normal;
   logic [DATA_W-1:0]   stat_fast;
   logic                fast_any;
   logic [DATA_W-1:0]   wdata;
   logic                bus_req;
   logic                wr_fire;
   logic [DATA_W-1:0]   rd_next;

   // ------------------------------------------------------------
   // bus handshake
   // ------------------------------------------------------------

   // request seen and not yet answered; write acts on the ack edge
   assign bus_req = cyc_i & stb_i & ~ack_reg;
   assign wr_fire = cyc_i & stb_i & we_i & ack_reg;
   assign wdata   = dat_i & lane_mask(sel_i);

   // ack pulse one cycle after the request is seen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req;
      end
   end

   // ------------------------------------------------------------
   // source sampling and status
   // ------------------------------------------------------------

   // peripheral lines land on bits 2..25
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periph_reg <= RESET_WORD;
      end else begin
         periph_reg <= {6'h00, periph_req_i, 2'h0};
      end
   end

   // raw and masked views; software bit bypasses the masks
   always_comb begin
      raw_normal                   = periph_reg;
      raw_normal[BIT_SOFTWARE]     = sw_ctrl_reg[SWC_NORMAL_BIT];
      raw_fast                     = periph_reg;
      raw_fast[BIT_SOFTWARE]       = sw_ctrl_reg[SWC_FAST_BIT];
      stat_fast                    = raw_fast & en_fast_reg;
      stat_fast[BIT_SOFTWARE]      = sw_ctrl_reg[SWC_FAST_BIT];
      stat_fast[BIT_FAST_SUMMARY]  = 1'b0;
      fast_any                     = |stat_fast[31:1];
      stat_fast[BIT_FAST_SUMMARY]  = fast_any;
      raw_fast[BIT_FAST_SUMMARY]   = fast_any;
      stat_normal                  = raw_normal & en_normal_reg;
      stat_normal[BIT_SOFTWARE]    = sw_ctrl_reg[SWC_NORMAL_BIT];
      stat_normal[BIT_FAST_SUMMARY] = fast_any;
      raw_normal[BIT_FAST_SUMMARY] = fast_any;
   end

   // request outputs to the core, no priority or vector logic
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_reg <= 1'b0;
         fiq_reg <= 1'b0;
      end else begin
         irq_reg <= |stat_normal;
         fiq_reg <= fast_any;
      end
   end

   // ------------------------------------------------------------
   // enable masks
   // ------------------------------------------------------------

   // set-only enables, one-to-clear, and mutual exclusion
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_normal_reg <= RESET_WORD;
         en_fast_reg   <= RESET_WORD;
      end else if (wr_fire) begin
         unique case (adr_i)
            ADDR_NORMAL_EN: begin
               en_normal_reg <= en_normal_reg | (wdata & SRC_MASK);
               en_fast_reg   <= en_fast_reg & ~(wdata & SRC_MASK);
            end
            ADDR_FAST_EN: begin
               en_fast_reg   <= en_fast_reg | (wdata & SRC_MASK);
               en_normal_reg <= en_normal_reg & ~(wdata & SRC_MASK);
            end
            ADDR_NORMAL_CLR: begin
               en_normal_reg <= en_normal_reg & ~wdata;
            end
            ADDR_FAST_CLR: begin
               en_fast_reg   <= en_fast_reg & ~wdata;
            end
            default: begin
               en_normal_reg <= en_normal_reg;
            end
         endcase
      end
   end

   // software request control, bits 1 and 2 only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sw_ctrl_reg <= RESET_WORD;
      end else if (wr_fire && adr_i == ADDR_SW_CONTROL) begin
         sw_ctrl_reg <= (sw_ctrl_reg & ~lane_mask(sel_i)) | (wdata & SWC_MASK);
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------

   // clear registers and unmapped addresses read zero
   always_comb begin
      unique case (adr_i)
         ADDR_NORMAL_STATUS: rd_next = stat_normal;
         ADDR_NORMAL_RAW:    rd_next = raw_normal;
         ADDR_NORMAL_EN:     rd_next = en_normal_reg;
         ADDR_SW_CONTROL:    rd_next = sw_ctrl_reg;
         ADDR_FAST_STATUS:   rd_next = stat_fast;
         ADDR_FAST_RAW:      rd_next = raw_fast;
         ADDR_FAST_EN:       rd_next = en_fast_reg;
         default:            rd_next = RESET_WORD;
      endcase
   end

   // read data held from the request edge through the ack cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_reg <= RESET_WORD;
      end else if (bus_req) begin
         rd_reg <= we_i ? RESET_WORD : rd_next;
      end
   end

   assign dat_o = rd_reg;
   assign ack_o = ack_reg;
   assign irq_o = irq_reg;
   assign fiq_o = fiq_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_masks_exclusive: assert property ((en_normal_reg & en_fast_reg) == 32'h00000000)
      else $error("source enabled on both paths");

   a_enable_set_only: assert property (wr_fire && adr_i == ADDR_NORMAL_EN |=>
      en_normal_reg == ($past(en_normal_reg) | ($past(wdata) & SRC_MASK)))
      else $error("normal enable write did not only set bits");

   a_normal_clear_ones: assert property (wr_fire && adr_i == ADDR_NORMAL_CLR |=>
      en_normal_reg == ($past(en_normal_reg) & ~$past(wdata)))
      else $error("normal clear wrong");

   a_fast_clear_ones: assert property (wr_fire && adr_i == ADDR_FAST_CLR |=>
      en_fast_reg == ($past(en_fast_reg) & ~$past(wdata)))
      else $error("fast clear wrong");

   a_raw_follows_line: assert property ($past(rst_i) == 1'b0 |->
      raw_normal[25:2] == $past(periph_req_i) && raw_fast[25:2] == $past(periph_req_i))
      else $error("raw source does not follow line");

   a_summary_bit_zero: assert property (stat_normal[0] == (|(raw_fast[31:1] & en_fast_reg[31:1])
      || sw_ctrl_reg[SWC_FAST_BIT]))
      else $error("fast summary bit wrong");

   a_normal_out_or: assert property (##1 irq_o == $past(|(raw_normal[31:1] & en_normal_reg[31:1])
      || sw_ctrl_reg[SWC_NORMAL_BIT] || fast_any))
      else $error("normal request output wrong");

   a_fast_out_late: assert property ($rose(fast_any) |=> fiq_o)
      else $error("fast request not raised");

   a_software_bypass: assert property (sw_ctrl_reg[SWC_NORMAL_BIT] |-> stat_normal[1] ##1 irq_o)
      else $error("software request masked");

   a_ack_one_cycle: assert property (ack_o |=> !ack_o)
      else $error("ack held too long");

   a_write_reads_zero: assert property (ack_o && $past(we_i) |-> dat_o == 32'h00000000)
      else $error("write answered with nonzero data");

   // ------------------------------------------------------------
   // checks on masks, status reads and reset
   // ------------------------------------------------------------

   // a fast enable write may only add bits
   a_fast_set_only: assert property (wr_fire && adr_i == ADDR_FAST_EN |=>
      en_fast_reg == ($past(en_fast_reg) | ($past(wdata) & SRC_MASK)))
      else $error("fast enable write did not only set bits");

   // a clear on one path must leave the other mask alone
   a_normal_clear_other: assert property (wr_fire && adr_i == ADDR_NORMAL_CLR |=>
      $stable(en_fast_reg))
      else $error("normal clear touched the fast mask");

   a_fast_clear_other: assert property (wr_fire && adr_i == ADDR_FAST_CLR |=>
      $stable(en_normal_reg))
      else $error("fast clear touched the normal mask");

   // status is read only; a write there changes nothing
   a_status_write_ignored: assert property (wr_fire && adr_i == ADDR_NORMAL_STATUS |=>
      $stable(en_normal_reg) && $stable(en_fast_reg) && $stable(sw_ctrl_reg))
      else $error("write to status changed state");

   // enables exist only on the source bit positions
   a_enable_bits_legal: assert property (((en_normal_reg | en_fast_reg) & ~SRC_MASK) == 32'h00000000)
      else $error("enable bit set outside the source positions");

   // read data of both status registers and the fast raw register as seen on the bus
   a_normal_status_read: assert property (bus_req && !we_i && adr_i == ADDR_NORMAL_STATUS |=>
      dat_o[25:2] == ($past(periph_reg[25:2]) & $past(en_normal_reg[25:2])))
      else $error("normal status read is not raw AND enable");

   a_fast_status_read: assert property (bus_req && !we_i && adr_i == ADDR_FAST_STATUS |=>
      dat_o[25:2] == ($past(periph_reg[25:2]) & $past(en_fast_reg[25:2])))
      else $error("fast status read is not raw AND enable");

   a_raw_read_line: assert property (bus_req && !we_i && adr_i == ADDR_FAST_RAW |=>
      dat_o[25:2] == $past(periph_reg[25:2]))
      else $error("fast raw read does not show the lines");

   // first edge after reset: masks, control and outputs all clear
   a_reset_clears_all: assert property ($past(rst_i) |->
      en_normal_reg == 32'h00000000 && en_fast_reg == 32'h00000000 &&
      sw_ctrl_reg == 32'h00000000 && !irq_o && !fiq_o)
      else $error("reset left a mask, control bit or request set");

   // fast output is the registered summary, one cycle behind
   a_fast_out_level: assert property (!$past(rst_i) |-> fiq_o == $past(fast_any))
      else $error("fast request output does not follow the summary");

   a_fast_soft_bypass: assert property (sw_ctrl_reg[SWC_FAST_BIT] |->
      stat_fast[1] && fast_any ##1 fiq_o)
      else $error("fast software request masked");

endmodule // irq_fiq_mask_status_unit

// file: logic/irq_fiq_pkg.sv
package irq_fiq_pkg;

   // ------------------------------------------------------------
   // bus and data widths
   // ------------------------------------------------------------
   localparam int          DATA_W   = 32;
   localparam int          ADDR_W   = 32;
   localparam int          SEL_W    = 4;
   localparam int          NUM_SRC  = 25;               // sources on bits 1..25
   localparam int          PERIPH_N = 24;               // hardware sources, bits 2..25

   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [31:0] ADDR_NORMAL_STATUS = 32'hffff0000;
   localparam logic [31:0] ADDR_NORMAL_RAW    = 32'hffff0004;
   localparam logic [31:0] ADDR_NORMAL_EN     = 32'hffff0008;
   localparam logic [31:0] ADDR_NORMAL_CLR    = 32'hffff000c;
   localparam logic [31:0] ADDR_SW_CONTROL    = 32'hffff0010;
   localparam logic [31:0] ADDR_FAST_STATUS   = 32'hffff0100;
   localparam logic [31:0] ADDR_FAST_RAW      = 32'hffff0104;
   localparam logic [31:0] ADDR_FAST_EN       = 32'hffff0108;
   localparam logic [31:0] ADDR_FAST_CLR      = 32'hffff010c;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int          BIT_FAST_SUMMARY = 0;
   localparam int          BIT_SOFTWARE     = 1;
   localparam int          BIT_PERIPH_LO    = 2;
   localparam int          BIT_PERIPH_HI    = 25;
   localparam int          SWC_NORMAL_BIT   = 1;        // software request, normal path
   localparam int          SWC_FAST_BIT     = 2;        // software request, fast path
   localparam logic [31:0] SRC_MASK         = 32'h03fffffe;
   localparam logic [31:0] SWC_MASK         = 32'h00000006;
   localparam logic [31:0] RESET_WORD       = 32'h00000000;

endpackage : irq_fiq_pkg

// file: tb/periph_request_model.sv
`timescale 1ns/1ps

// ---------------------------------------------
// peripheral request lines, level held until cleared
// ---------------------------------------------
module periph_request_model
   import irq_fiq_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic [PERIPH_N-1:0] want_i,
   output logic      [PERIPH_N-1:0] req_o
);
   // each peripheral raises or drops its request on the system clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_o <= '0;
      end else begin
         req_o <= want_i;
      end
   end
endmodule // periph_request_model

// file: tb/test_irq_fiq_mask_status_unit.sv
`timescale 1ns/1ps

// ---------------------------------------------
// bench for the mask and status unit
// ---------------------------------------------
module test_irq_fiq_mask_status_unit
   import irq_fiq_pkg::*;
;
   logic                clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [31:0]         adr_i = '0, dat_i = '0, en_n = '0, en_f = '0, sw = '0, r = 32'hcc47;
   logic [3:0]          sel_i = '0;
   logic [23:0]         want = '0, req;
   logic [31:0]         dat_o;
   logic                ack_o, irq_o, fiq_o;
   logic [33:0]         exp_q[$];
   logic [33:0]         exp_v;
   int                  n_mismatch = 0, comparisons = 0, cycles = 0;
   logic [31:0]         rd_tab[10] = '{ADDR_NORMAL_STATUS, ADDR_FAST_STATUS, ADDR_NORMAL_RAW, ADDR_NORMAL_EN,
                                       ADDR_NORMAL_CLR, ADDR_SW_CONTROL, ADDR_FAST_RAW, ADDR_FAST_EN,
                                       ADDR_FAST_CLR, 32'hffff0200};

   always #4 clk_i = ~clk_i;

   periph_request_model src_u (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .req_o(req));
   irq_fiq_mask_status_unit dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .periph_req_i(req),
      .irq_o(irq_o), .fiq_o(fiq_o));

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // expected {irq, fiq, read data} from the reference state
   function automatic logic [33:0] expect_rd(input logic [31:0] a);
      logic [31:0] sf, sn, v;
      logic        summ;
      sf = {6'h0, want & en_f[25:2], sw[2], 1'b0};
      summ = |sf;
      sn = {6'h0, want & en_n[25:2], sw[1], summ};
      case (a)
         ADDR_NORMAL_STATUS: v = sn;
         ADDR_FAST_STATUS:   v = {sf[31:1], summ};
         ADDR_NORMAL_RAW:    v = {6'h0, want, sw[1], summ};
         ADDR_FAST_RAW:      v = {6'h0, want, sw[2], summ};
         ADDR_NORMAL_EN:     v = en_n;
         ADDR_FAST_EN:       v = en_f;
         ADDR_SW_CONTROL:    v = sw;
         default:            v = '0;
      endcase
      return {|sn, summ, v};
   endfunction

   // one classic cycle, held until ack is sampled high
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a);
      exp_q.push_back(expect_rd(a));
      bus(1'b0, a, '0, 4'hf);
   endtask

   // write with the reference state updated alongside
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] l, m;
      l = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      m = d & l;
      case (a)
         ADDR_NORMAL_EN:  begin en_n |= m & SRC_MASK; en_f &= ~(m & SRC_MASK); end
         ADDR_FAST_EN:    begin en_f |= m & SRC_MASK; en_n &= ~(m & SRC_MASK); end
         ADDR_NORMAL_CLR: en_n &= ~m;
         ADDR_FAST_CLR:   en_f &= ~m;
         ADDR_SW_CONTROL: sw = (sw & ~l) | (m & SWC_MASK);
         default:         ;
      endcase
      bus(1'b1, a, d, s);
   endtask

   task automatic results();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ---------------------------------------------
   // checking and stimulus
   // ---------------------------------------------
   // compare each read answer with the oldest note
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
         exp_v = exp_q.pop_front();
         comparisons++;
         if ({irq_o, fiq_o, dat_o} !== exp_v) begin
            n_mismatch++;
            $display("wrong value at %0t: adr %h got %h exp %h", $time, adr_i, {irq_o, fiq_o, dat_o}, exp_v);
         end
      end
   end

   // cuts a hang short
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         results();
      end
   end

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rd_tab[i]) rd(rd_tab[i]);
      repeat (150) begin
         r = lfsr(lfsr(r));
         case (r[2:0])
            3'd0: wr(ADDR_NORMAL_EN, lfsr(r), r[7:4]);
            3'd1: wr(ADDR_FAST_EN, lfsr(r), r[7:4]);
            3'd2: wr(ADDR_NORMAL_CLR, lfsr(r) & ~{6'h00, want, 2'h0}, r[7:4]);
            3'd3: wr(ADDR_FAST_CLR, lfsr(r) & ~{6'h00, want, 2'h0}, r[7:4]);
            3'd4: wr(ADDR_SW_CONTROL, lfsr(r), r[7:4]);
            3'd5: want <= r[31:8];
            3'd6: wr(ADDR_NORMAL_STATUS, lfsr(r), 4'hf);
            3'd7: wr(32'hffff0200, lfsr(r), 4'hf);
         endcase
         repeat (5) @(posedge clk_i);
         foreach (rd_tab[i]) rd(rd_tab[i]);
      end
      // reset in mid-run: masks and control clear, raw lines still seen
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      en_n = '0;
      en_f = '0;
      sw = '0;
      repeat (5) @(posedge clk_i);
      foreach (rd_tab[i]) rd(rd_tab[i]);
      repeat (4) @(posedge clk_i);
      if (exp_q.size() != 0) begin
         n_mismatch++;
         $display("wrong value at %0t: %0d reads never answered", $time, exp_q.size());
      end
      results();
   end
endmodule // test_irq_fiq_mask_status_unit
